// >>> pdc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.vh"
// ----------------------------------------
// pll divider configuration top
// ----------------------------------------
module pdc_top
(
	input  wire        I_REF_CLK,
	input  wire        I_RESETN,
	input  wire        I_SCLK,
	input  wire        I_CS_N,
	input  wire        I_SDIO,
	input  wire        I_LOSS_OF_LOCK_V,
	input  wire        I_LOSS_OF_LOCK_F,
	output reg         O_SDIO,
	output reg         O_SDIO_OE,
	output reg         O_SDO,
	output reg         O_SDO_OE,
	output reg         O_LOCK,
	output reg  [11:0] O_PRIMARY_FB_DIV,
	output reg  [8:0]  O_SECONDARY_FB_DIV,
	output reg         O_SECONDARY_DIV_EN,
	output reg         O_FB_USE_PRODUCT,
	output reg  [2:0]  O_FB_DETECT_PHASE,
	output reg  [2:0]  O_PREDIV_DETECT_PHASE,
	output reg  [11:0] O_FIRST_INPUT_PREDIV,
	output reg         O_FIRST_STAGE_EN,
	output reg  [8:0]  O_SECOND_FB_PREDIV,
	output reg  [5:0]  O_SECOND_INPUT_PREDIV,
	output reg         O_SECOND_PREDIV_BYPASS,
	output reg         O_DOUBLER_EN,
	output reg         O_SECOND_STAGE_EN,
	output reg         O_CHANNEL_FROM_FIRST,
	output reg         O_SERIAL_PIN_LEVEL,
	output reg         O_STATUS_PIN_LEVEL
);
	wire [6:0]  addr;
	wire [7:0]  wdata;
	wire        wr;
	wire        rd_phase;
	wire        sout;
	wire [7:0]  rdata;
	wire [11:0] mv;
	wire [8:0]  sec;
	wire        sec_pd;
	wire [2:0]  fb_ph;
	wire        fb_byp;
	wire [11:0] ipre;
	wire [2:0]  ipre_ph;
	wire [8:0]  sfb;
	wire        byp_v;
	wire [5:0]  spre;
	wire        dbl;
	wire        src;
	wire        lmask;
	wire        pmode;
	wire        selsv;
	wire        selst;

	pdc_spi_shift u_spi
	(
		.clk        (I_REF_CLK),
		.rst_n      (I_RESETN),
		.i_sclk     (I_SCLK),
		.i_cs_n     (I_CS_N),
		.i_sdio     (I_SDIO),
		.i_rdata    (rdata),
		.o_addr     (addr),
		.o_wdata    (wdata),
		.o_wr       (wr),
		.o_rd_phase (rd_phase),
		.o_sout     (sout)
	);

	pdc_regfile u_regs
	(
		.clk      (I_REF_CLK),
		.rst_n    (I_RESETN),
		.i_addr   (addr),
		.i_wdata  (wdata),
		.i_wr     (wr),
		.o_rdata  (rdata),
		.o_mv     (mv),
		.o_sec    (sec),
		.o_sec_pd (sec_pd),
		.o_fb_ph  (fb_ph),
		.o_fb_byp (fb_byp),
		.o_ipre    (ipre),
		.o_ipre_ph (ipre_ph),
		.o_sfb     (sfb),
		.o_byp_v   (byp_v),
		.o_spre    (spre),
		.o_dbl    (dbl),
		.o_src    (src),
		.o_lmask  (lmask),
		.o_pmode  (pmode),
		.o_selsv  (selsv),
		.o_selst  (selst),
		.o_misc   ()
	);

	// ----------------------------------------
	// registered control outputs
	// ----------------------------------------
	always @(posedge I_REF_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			O_SDIO                 <= 1'b0;
			O_SDIO_OE              <= 1'b0;
			O_SDO                  <= 1'b0;
			O_SDO_OE               <= 1'b0;
			O_LOCK                 <= 1'b0;
			O_PRIMARY_FB_DIV       <= `PDC_RST_R12;
			O_SECONDARY_FB_DIV     <= `PDC_RST_R9;
			O_SECONDARY_DIV_EN     <= 1'b1;
			O_FB_USE_PRODUCT       <= 1'b0;
			O_FB_DETECT_PHASE      <= `PDC_RST_FBPH;
			O_PREDIV_DETECT_PHASE  <= `PDC_RST_PH;
			O_FIRST_INPUT_PREDIV   <= `PDC_RST_R12;
			O_FIRST_STAGE_EN       <= 1'b1;
			O_SECOND_FB_PREDIV     <= `PDC_RST_R9;
			O_SECOND_INPUT_PREDIV  <= 6'h00;
			O_SECOND_PREDIV_BYPASS <= 1'b1;
			O_DOUBLER_EN           <= 1'b0;
			O_SECOND_STAGE_EN      <= 1'b1;
			O_CHANNEL_FROM_FIRST   <= 1'b0;
			O_SERIAL_PIN_LEVEL     <= 1'b0;
			O_STATUS_PIN_LEVEL     <= 1'b0;
		end
		else
		begin
			// R01 R02 ratios, out-of-range left to host
			O_PRIMARY_FB_DIV      <= mv;
			O_SECONDARY_FB_DIV    <= sec;
			// R03 power-down gating
			O_SECONDARY_DIV_EN    <= ~sec_pd;
			// R16 product feedback select
			O_FB_USE_PRODUCT      <= fb_byp;
			// R05 lock-detect window
			O_FB_DETECT_PHASE     <= fb_ph;
			O_PREDIV_DETECT_PHASE <= ipre_ph;
			// R06 R07 predividers
			O_FIRST_INPUT_PREDIV  <= ipre;
			O_SECOND_FB_PREDIV    <= sfb;
			// R17 first-stage bypass
			O_FIRST_STAGE_EN      <= ~byp_v;
			// R09 doubler selection
			O_DOUBLER_EN          <= dbl;
			// R10 predivider ignored when doubling
			O_SECOND_INPUT_PREDIV <= dbl ? 6'h00 : spre;
			// R08 zero means bypass
			O_SECOND_PREDIV_BYPASS <= dbl | (spre == 6'h00);
			// R11 R12 second-stage source
			O_SECOND_STAGE_EN     <= ~src;
			O_CHANNEL_FROM_FIRST  <= src;
			// R13 lock masking; second-stage loss of lock ignored while that stage is bypassed
			O_LOCK <= ~((I_LOSS_OF_LOCK_V & ~lmask) | (I_LOSS_OF_LOCK_F & ~src));
			O_SERIAL_PIN_LEVEL    <= selsv;
			O_STATUS_PIN_LEVEL    <= selst;
			// R14 3-wire read on data pin
			O_SDIO                <= sout;
			O_SDIO_OE             <= rd_phase & ~pmode & ~I_CS_N;
			// R15 4-wire read on output pin
			O_SDO                 <= sout;
			O_SDO_OE              <= rd_phase & pmode & ~I_CS_N;
		end
	end
endmodule // pdc_top
`default_nettype wire

// >>> pdc_defines.vh
// How it works
// R01 - primary feedback divider ratio is 12 bits, range 1..4095, resets to 3072
// R02 - secondary feedback divider ratio is 9 bits, range 4..511, resets to 30
// R03 - power-down bit set disables secondary divider; clear (reset) keeps it enabled
// R04 - host sets power-down when input clock monitors are unused
// R05 - 3-bit predivider detect phase, codes 010..111, resets to 101
// R06 - first-stage input predivider is 12 bits, 1..4095, resets to 3072
// R07 - second-stage feedback predivider is 9 bits, 8..511, resets to 30
// R08 - second-stage input predivider is 6 bits, 1..63; zero means bypass
// R09 - doubler set doubles first-stage mux output, else divides by input predivider
// R10 - with doubler set, input predivider setting has no effect
// R11 - output source clear: second-stage PLL enabled and feeds channel dividers
// R12 - output source set: second stage bypassed, channels divide first-stage output
// R13 - lock mask set hides first-stage loss of lock from lock pin
// R14 - port mode clear: 3-wire, data pin bidirectional, dedicated output pin floats
// R15 - port mode set: 4-wire, read data driven on dedicated output pin
// R16 - feedback bypass set: feedback ratio is primary times secondary, else primary
// R17 - first-stage bypass mux passes PLL output; bypass control set bypasses it
// R18 - every field reads back last written value and resets to its default
// R19 - host must not write out-of-range ratios such as zero
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define PDC_A_FB0     7'h00
`define PDC_A_FB1     7'h01
`define PDC_A_SEC0    7'h02
`define PDC_A_SEC1    7'h03
`define PDC_A_PV0     7'h04
`define PDC_A_PV1     7'h05
`define PDC_A_MF0     7'h08
`define PDC_A_MF1     7'h09
`define PDC_A_BYP1    7'h0A
`define PDC_A_SPRE    7'h0C
`define PDC_A_MISC    7'h1F
// ----------------------------------------
// reset values
// ----------------------------------------
`define PDC_RST_R12   12'hC00
`define PDC_RST_R9    9'h01E
`define PDC_RST_PH    3'h5
`define PDC_RST_FBPH  3'h5
`define PDC_RST_MOD   4'h0
// ----------------------------------------
// frame layout
// ----------------------------------------
`define PDC_ADDR_W    7
`define PDC_HDR_BITS  4'h8
`define PDC_DAT_BITS  4'h8
`endif

// >>> pdc_spi_shift.v
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.vh"
// ----------------------------------------
// spi frame engine, mode 0, msb first
// ----------------------------------------
module pdc_spi_shift
(
	input  wire       clk,
	input  wire       rst_n,
	input  wire       i_sclk,
	input  wire       i_cs_n,
	input  wire       i_sdio,
	input  wire [7:0] i_rdata,
	output reg  [6:0] o_addr,
	output reg  [7:0] o_wdata,
	output reg        o_wr,
	output reg        o_rd_phase,
	output reg        o_sout
);
	reg       sclk_q;
	reg [3:0] cnt;
	reg       hdr;
	reg       is_rd;
	reg [7:0] sh;
	reg [7:0] rsh;
	wire      rise = i_sclk & ~sclk_q;
	wire      fall = ~i_sclk & sclk_q;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_q     <= 1'b0;
			cnt        <= 4'h0;
			hdr        <= 1'b1;
			is_rd      <= 1'b0;
			sh         <= 8'h00;
			rsh        <= 8'h00;
			o_addr     <= 7'h00;
			o_wdata    <= 8'h00;
			o_wr       <= 1'b0;
			o_rd_phase <= 1'b0;
			o_sout     <= 1'b0;
		end
		else
		begin
			sclk_q <= i_sclk;
			o_wr   <= 1'b0;
			// step address only after the write strobe has used it
			if (o_wr)
				o_addr <= o_addr + 7'h01;
			if (i_cs_n)
			begin
				cnt        <= 4'h0;
				hdr        <= 1'b1;
				o_rd_phase <= 1'b0;
			end
			else if (rise)
			begin
				sh <= {sh[6:0], i_sdio};
				if (cnt == `PDC_HDR_BITS - 4'h1)
				begin
					cnt <= 4'h0;
					if (hdr)
					begin
						// header: rw bit then address
						hdr    <= 1'b0;
						is_rd  <= sh[6];
						o_addr <= {sh[5:0], i_sdio};
					end
					else
					begin
						// data byte; auto-increment for streaming
						if (!is_rd)
						begin
							o_wdata <= {sh[6:0], i_sdio};
							o_wr    <= 1'b1;
						end
						else
							o_addr <= o_addr + 7'h01;
					end
				end
				else
					cnt <= cnt + 4'h1;
			end
			else if (fall)
			begin
				// load read byte right after header or data byte ends
				if (!hdr && is_rd && cnt == 4'h0)
				begin
					o_rd_phase <= 1'b1;
					o_sout     <= i_rdata[7];
					rsh        <= {i_rdata[6:0], 1'b0};
				end
				else if (o_rd_phase)
				begin
					o_sout <= rsh[7];
					rsh    <= {rsh[6:0], 1'b0};
				end
			end
		end
	end
endmodule // pdc_spi_shift
`default_nettype wire

// >>> pdc_regfile.v
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.vh"
// ----------------------------------------
// configuration storage
// ----------------------------------------
module pdc_regfile
(
	input  wire        clk,
	input  wire        rst_n,
	input  wire [6:0]  i_addr,
	input  wire [7:0]  i_wdata,
	input  wire        i_wr,
	output reg  [7:0]  o_rdata,
	output reg  [11:0] o_mv,
	output reg  [8:0]  o_sec,
	output reg         o_sec_pd,
	output reg  [2:0]  o_fb_ph,
	output reg         o_fb_byp,
	output reg  [11:0] o_ipre,
	output reg  [2:0]  o_ipre_ph,
	output reg  [8:0]  o_sfb,
	output reg         o_byp_v,
	output reg  [5:0]  o_spre,
	output reg         o_dbl,
	output reg         o_src,
	output reg         o_lmask,
	output reg         o_pmode,
	output reg         o_selsv,
	output reg         o_selst,
	output reg  [4:0]  o_misc
);
	// ----------------------------------------
	// writes
	// ----------------------------------------
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// R01 R06 default ratios
			o_mv      <= `PDC_RST_R12;
			o_ipre    <= `PDC_RST_R12;
			// R02 R07 default ratios
			o_sec     <= `PDC_RST_R9;
			o_sfb     <= `PDC_RST_R9;
			o_sec_pd  <= 1'b0;
			// R05 phase default
			o_ipre_ph <= `PDC_RST_PH;
			o_fb_ph   <= `PDC_RST_FBPH;
			o_fb_byp  <= 1'b0;
			o_byp_v   <= 1'b0;
			// R08 bypass default
			o_spre    <= 6'h00;
			o_dbl    <= 1'b0;
			o_src    <= 1'b0;
			o_lmask  <= 1'b0;
			o_pmode  <= 1'b0;
			o_selsv  <= 1'b0;
			o_selst  <= 1'b0;
			o_misc   <= 5'h00;
		end
		else if (i_wr)
		begin
			// R18 store written fields
			case (i_addr)
			`PDC_A_FB0:
			begin
				o_fb_ph     <= i_wdata[7:5];
				o_sec_pd    <= i_wdata[4];
				o_mv[11:8]  <= i_wdata[3:0];
			end
			`PDC_A_FB1:  o_mv[7:0]  <= i_wdata;
			`PDC_A_SEC0: o_sec[7:0] <= i_wdata;
			`PDC_A_SEC1:
			begin
				o_sec[8] <= i_wdata[7];
				o_fb_byp <= i_wdata[0];
			end
			`PDC_A_PV0:
			begin
				o_ipre_ph    <= i_wdata[7:5];
				o_ipre[11:8] <= i_wdata[3:0];
			end
			`PDC_A_PV1:  o_ipre[7:0] <= i_wdata;
			`PDC_A_MF0:  o_sfb[8]    <= i_wdata[0];
			`PDC_A_MF1:  o_sfb[7:0]  <= i_wdata;
			`PDC_A_BYP1: o_byp_v     <= i_wdata[0];
			`PDC_A_SPRE:
			begin
				o_dbl  <= i_wdata[7];
				o_src  <= i_wdata[6];
				o_spre <= i_wdata[5:0];
			end
			`PDC_A_MISC:
			begin
				o_lmask <= i_wdata[7];
				o_pmode <= i_wdata[6];
				o_selst <= i_wdata[5];
				o_selsv <= i_wdata[4];
				o_misc  <= {1'b0, i_wdata[3:0]};
			end
			default: ;
			endcase
		end
	end

	// ----------------------------------------
	// readback, reserved bits as zero
	// ----------------------------------------
	always @*
	begin
		case (i_addr)
		`PDC_A_FB0:  o_rdata = {o_fb_ph, o_sec_pd, o_mv[11:8]};
		`PDC_A_FB1:  o_rdata = o_mv[7:0];
		`PDC_A_SEC0: o_rdata = o_sec[7:0];
		`PDC_A_SEC1: o_rdata = {o_sec[8], 6'h00, o_fb_byp};
		`PDC_A_PV0:  o_rdata = {o_ipre_ph, 1'b0, o_ipre[11:8]};
		`PDC_A_PV1:  o_rdata = o_ipre[7:0];
		`PDC_A_MF0:  o_rdata = {7'h00, o_sfb[8]};
		`PDC_A_MF1:  o_rdata = o_sfb[7:0];
		`PDC_A_BYP1: o_rdata = {7'h00, o_byp_v};
		`PDC_A_SPRE: o_rdata = {o_dbl, o_src, o_spre};
		`PDC_A_MISC: o_rdata = {o_lmask, o_pmode, o_selst, o_selsv, o_misc[3:0]};
		default:     o_rdata = 8'h00;
		endcase
	end
endmodule // pdc_regfile
`default_nettype wire

// >>> pdc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module pdc_top_sva
(
	input wire logic        I_REF_CLK,
	input wire logic        I_RESETN,
	input wire logic        I_CS_N,
	input wire logic        I_LOSS_OF_LOCK_V,
	input wire logic        I_LOSS_OF_LOCK_F,
	input wire logic        O_SDIO_OE,
	input wire logic        O_SDO_OE,
	input wire logic        O_LOCK,
	input wire logic [11:0] O_PRIMARY_FB_DIV,
	input wire logic [8:0]  O_SECONDARY_FB_DIV,
	input wire logic        O_SECONDARY_DIV_EN,
	input wire logic [11:0] O_FIRST_INPUT_PREDIV,
	input wire logic [8:0]  O_SECOND_FB_PREDIV,
	input wire logic [5:0]  O_SECOND_INPUT_PREDIV,
	input wire logic        O_SECOND_PREDIV_BYPASS,
	input wire logic        O_DOUBLER_EN,
	input wire logic        O_SECOND_STAGE_EN,
	input wire logic        O_CHANNEL_FROM_FIRST
);
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RESETN);
	a_reset_ratios:
	assert property ($rose(I_RESETN) |-> O_PRIMARY_FB_DIV == 12'hC00
		&& O_FIRST_INPUT_PREDIV == 12'hC00 && O_SECONDARY_FB_DIV == 9'h01E
		&& O_SECOND_FB_PREDIV == 9'h01E) else $error("ratios not at defaults");
	a_reset_modes:
	assert property ($rose(I_RESETN) |-> O_SECOND_PREDIV_BYPASS && O_SECOND_STAGE_EN
		&& O_SECONDARY_DIV_EN && !O_DOUBLER_EN) else $error("modes not at defaults");
	a_source_pair:
	assert property (O_SECOND_STAGE_EN == !O_CHANNEL_FROM_FIRST)
		else $error("source outputs disagree");
	a_doubler_hides:
	assert property (O_DOUBLER_EN |-> O_SECOND_PREDIV_BYPASS && O_SECOND_INPUT_PREDIV == 6'h00)
		else $error("predivider visible while doubling");
	a_prediv_zero:
	assert property (!O_DOUBLER_EN |-> O_SECOND_PREDIV_BYPASS == (O_SECOND_INPUT_PREDIV == 6'h00))
		else $error("bypass does not follow zero ratio");
	a_oe_exclusive:
	assert property (!(O_SDIO_OE && O_SDO_OE)) else $error("both read pins driven");
	a_oe_idle:
	assert property (I_CS_N && $past(I_CS_N) && $past(I_CS_N, 2) |-> !O_SDIO_OE && !O_SDO_OE)
		else $error("read pin driven while deselected");
	a_lock_clear:
	assert property ($past(I_RESETN) && $past(!I_LOSS_OF_LOCK_V && !I_LOSS_OF_LOCK_F) |-> O_LOCK)
		else $error("lock low without loss of lock");
endmodule // pdc_top_sva
bind pdc_top pdc_top_sva u_sva (.I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN), .I_CS_N(I_CS_N),
	.I_LOSS_OF_LOCK_V(I_LOSS_OF_LOCK_V), .I_LOSS_OF_LOCK_F(I_LOSS_OF_LOCK_F),
	.O_SDIO_OE(O_SDIO_OE), .O_SDO_OE(O_SDO_OE), .O_LOCK(O_LOCK),
	.O_PRIMARY_FB_DIV(O_PRIMARY_FB_DIV), .O_SECONDARY_FB_DIV(O_SECONDARY_FB_DIV),
	.O_SECONDARY_DIV_EN(O_SECONDARY_DIV_EN), .O_FIRST_INPUT_PREDIV(O_FIRST_INPUT_PREDIV),
	.O_SECOND_FB_PREDIV(O_SECOND_FB_PREDIV), .O_SECOND_INPUT_PREDIV(O_SECOND_INPUT_PREDIV),
	.O_SECOND_PREDIV_BYPASS(O_SECOND_PREDIV_BYPASS), .O_DOUBLER_EN(O_DOUBLER_EN),
	.O_SECOND_STAGE_EN(O_SECOND_STAGE_EN), .O_CHANNEL_FROM_FIRST(O_CHANNEL_FROM_FIRST));
`default_nettype wire

// >>> pdc_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// spi host model, mode 0
// ----------------------------------------
module pdc_spi_host
(
	input  wire logic i_clk,
	input  wire logic i_sdio,
	input  wire logic i_sdo,
	output var  logic o_sclk,
	output var  logic o_cs_n,
	output var  logic o_mosi,
	output var  logic o_mosi_oe
);
	initial
	begin
		o_sclk = 1'h0;
		o_cs_n = 1'h1;
		o_mosi = 1'h0;
		o_mosi_oe = 1'h1;
	end
	// callers pick in-range ratios
	// one byte a frame; slow halves so sampling is safe
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
		input logic four, output logic [7:0] q);
		logic [15:0] sh;
		sh = {rd, a, wd};
		@(posedge i_clk) o_cs_n <= 1'h0;
		for (int i = 15; i >= 0; i--)
		begin
			@(posedge i_clk) o_sclk <= 1'h0;
			o_mosi <= sh[i];
			// release data pin in 3-wire reads
			o_mosi_oe <= !(rd && i < 8 && !four);
			repeat (4) @(posedge i_clk);
			@(negedge i_clk) q = {q[6:0], four ? i_sdo : i_sdio};
			@(posedge i_clk) o_sclk <= 1'h1;
			repeat (2) @(posedge i_clk);
		end
		@(posedge i_clk) o_sclk <= 1'h0;
		@(posedge i_clk) o_cs_n <= 1'h1;
		repeat (3) @(posedge i_clk);
		o_mosi_oe <= 1'h1;
		repeat (2) @(posedge i_clk);
	endtask
endmodule // pdc_spi_host
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk, rst_n, lol_v, lol_f, four, tog;
	logic        sclk, cs_n, mosi, mosi_oe;
	logic [7:0]  q;
	int          err_count, checked;
	wire         sdio, sdio_oe, dedicated_output_pin, sdo_oe, lock, sec_en, fb_prod, st1_en, spre_byp;
	wire         dbl, st2_en, ch1, lvl_s, lvl_t, sdio_w, sdo_w;
	wire  [11:0] fb, ipre;
	wire  [8:0]  sec, sfb;
	wire  [5:0]  spre;
	wire  [2:0]  fb_ph, ipre_ph;
	logic [6:0]  ta [18] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h08, 7'h09, 7'h0A,
		7'h0C, 7'h06, 7'h00, 7'h01, 7'h02, 7'h03, 7'h0C, 7'h0C, 7'h0A};
	logic [7:0]  tw [18] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h51, 8'h01, 8'hFE, 8'h08, 8'hFF,
		8'h3F, 8'hFF, 8'h40, 8'h01, 8'h04, 8'h00, 8'hBF, 8'h40, 8'h00};
	logic [7:0]  tr [18] = '{8'hFF, 8'hFF, 8'hFF, 8'h81, 8'h41, 8'h01, 8'h00, 8'h08, 8'h01,
		8'h3F, 8'h00, 8'h40, 8'h01, 8'h04, 8'h00, 8'hBF, 8'h40, 8'h00};
	logic [7:0]  dflt [11] = '{8'hAC, 8'h00, 8'h1E, 8'h00, 8'hAC, 8'h00, 8'h00, 8'h1E, 8'h00,
		8'h00, 8'h00};
	// released lines show a changing pattern, not the last value
	assign sdio_w = sdio_oe ? sdio : (mosi_oe ? mosi : tog);
	assign sdo_w = sdo_oe ? dedicated_output_pin : tog;
	always #12.5 clk = ~clk;
	always @(posedge clk) tog <= ~tog;
	pdc_spi_host host (.i_clk(clk), .i_sdio(sdio_w), .i_sdo(sdo_w), .o_sclk(sclk),
		.o_cs_n(cs_n), .o_mosi(mosi), .o_mosi_oe(mosi_oe));
	pdc_top dut (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_SCLK(sclk), .I_CS_N(cs_n),
		.I_SDIO(sdio_w), .I_LOSS_OF_LOCK_V(lol_v), .I_LOSS_OF_LOCK_F(lol_f), .O_SDIO(sdio),
		.O_SDIO_OE(sdio_oe), .O_SDO(dedicated_output_pin), .O_SDO_OE(sdo_oe), .O_LOCK(lock),
		.O_PRIMARY_FB_DIV(fb), .O_SECONDARY_FB_DIV(sec), .O_SECONDARY_DIV_EN(sec_en),
		.O_FB_USE_PRODUCT(fb_prod), .O_FB_DETECT_PHASE(fb_ph),
		.O_PREDIV_DETECT_PHASE(ipre_ph), .O_FIRST_INPUT_PREDIV(ipre),
		.O_FIRST_STAGE_EN(st1_en), .O_SECOND_FB_PREDIV(sfb),
		.O_SECOND_INPUT_PREDIV(spre), .O_SECOND_PREDIV_BYPASS(spre_byp), .O_DOUBLER_EN(dbl),
		.O_SECOND_STAGE_EN(st2_en), .O_CHANNEL_FROM_FIRST(ch1), .O_SERIAL_PIN_LEVEL(lvl_s),
		.O_STATUS_PIN_LEVEL(lvl_t));
	// wide enough for the joined ratio compares
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer(1'h0, a, d, four, q);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		host.xfer(1'h1, a, 8'h00, four, q);
		chk(q, e);
	endtask
	task automatic run(input int lo, input int hi);
		for (int i = lo; i < hi; i++)
		begin
			wr(ta[i], tw[i]);
			rd(ta[i], tr[i]);
		end
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge clk);
		err_count++;
		end_sim;
	end
	initial
	begin
		{clk, rst_n, lol_v, lol_f, four, tog, err_count, checked} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk);
		chk(fb, 12'hC00);
		chk(sec, 9'h01E);
		chk(sec_en, 1'h1);
		chk(ipre_ph, 3'h5);
		chk(ipre, 12'hC00);
		chk(sfb, 9'h01E);
		chk(spre_byp, 1'h1);
		chk(st2_en, 1'h1);
		chk(fb_prod, 1'h0);
		chk(st1_en, 1'h1);
		for (int i = 0; i < 11; i++)
			rd(ta[i], dflt[i]);
		$display("test defaults done");
		run(0, 11);
		chk(fb, 12'hFFF);
		chk(sec, 9'h1FF);
		chk(sec_en, 1'h0);
		chk({fb_ph, ipre_ph}, 6'h3A);
		chk(ipre, 12'h101);
		chk(sfb, 9'h008);
		chk({spre_byp, spre}, 7'h3F);
		chk({fb_prod, st1_en}, 2'h2);
		run(11, 16);
		chk({fb, sec}, 21'h0_0204);
		chk({dbl, spre_byp, spre}, 8'hC0);
		run(16, 18);
		chk({st2_en, ch1, st1_en}, 3'h3);
		$display("test fields done");
		lol_v <= 1'h1;
		repeat (3) @(posedge clk);
		chk(lock, 1'h0);
		wr(7'h1F, 8'h80);
		lol_f <= 1'h1;
		repeat (3) @(posedge clk);
		chk(lock, 1'h1);
		$display("test lock done");
		wr(7'h1F, 8'h70);
		chk({lvl_s, lvl_t}, 2'h3);
		four = 1'h1;
		rd(7'h1F, 8'h70);
		rd(7'h02, 8'h04);
		wr(7'h1F, 8'h00);
		four = 1'h0;
		rd(7'h1F, 8'h00);
		$display("test port mode done");
		rst_n <= 1'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk);
		rd(7'h00, 8'hAC);
		$display("test second reset done");
		end_sim;
	end
endmodule // tb_top
`default_nettype wire
